// *** pgc_defs.vh ***
/*
 * constants for the pattern generator and error checker: mode codes,
 * pattern words, seed, lock and loss thresholds, timing and fifo sizing.
 * assumes a single 100 mhz clock and one test bit per strobe.
 */
`ifndef PGC_DEFS_VH
`define PGC_DEFS_VH

// mode codes shared by generator and checker
`define PGC_M_P9      4'h0
`define PGC_M_P11     4'h1
`define PGC_M_P15     4'h2
`define PGC_M_P20     4'h3
`define PGC_M_P20Q    4'h4
`define PGC_M_P23     4'h5
`define PGC_M_P29     4'h6
`define PGC_M_P31     4'h7
`define PGC_M_ONES    4'h8
`define PGC_M_ALT     4'h9
`define PGC_M_ONE3    4'hA
`define PGC_M_USRA    4'hB
`define PGC_M_USRB    4'hC
`define PGC_M_USRW    4'hD

// fixed pattern words, sent msb first over their length
`define PGC_PW_ONES   16'h0001
`define PGC_PW_ALT    16'h0002
`define PGC_PW_ONE3   16'h0008

// shift register seed, never the all-zero state
`define PGC_SEED      31'h7FFF_FFFF

// consecutive correct predictions needed to lock
`define PGC_SYNC_BITS 7'h40
// phase-offset detector: run length and least errors in that run
`define PGC_OOP_BITS  7'h40
`define PGC_OOP_ERRS  7'h10
// loss threshold 0.20 as error times five above bits
`define PGC_LOSS_MUL  3'h5

// timing
`define PGC_CLK_PERIOD_NS 10
`define PGC_LOSS_WIN_S    1
`define PGC_NS_PER_S      1000000000

// fifo in the transmit path
`define PGC_FIFO_DEPTH 16
`define PGC_FIFO_AW    4

`endif

// *** pgc_top.v ***
/*
 * prbs and fixed pattern generator with bit error checker, plus the
 * transmit fifo. assumes transmit bits are drained by tx_ready_in on
 * clk_in, and received rails plus strobe arrive asynchronously.
 */
//
// What this block does
// RL1: generator is an n-stage feedback shift register, period 2^n-1.
// RL2: every n-bit state once per period; all-zero state never entered.
// RL3: 9-stage mode, taps 5 and 9, output not inverted.
// RL4: 11-stage mode, taps 9 and 11, output not inverted.
// RL5: 15-stage mode, taps 14 and 15, output inverted.
// RL6: 20-stage mode, taps 3 and 20, output not inverted.
// RL7: 20-stage taps 17/20 variant, one forced ahead of 14 coming zeros.
// RL8: 23-stage mode, taps 18 and 23, output inverted.
// RL9: fixed all ones, alternating and one-three-zeros patterns.
// RL10: two programmable 8-bit and one 16-bit repeating pattern.
// RL11: received rails decoded to binary before bitwise comparison.
// RL12: errors counted only while reference is locked.
// RL13: lock lost when error ratio exceeds 0.20 over one second.
// RL14: lock lost when sequences are found out of phase.
// RL15: out of phase when error pattern obeys the prbs recurrence.
// RL16: optional ami comparison against an ami-coded reference.
// RL17: errors and bits counted over a configured interval.
// RL18: 29-stage and 31-stage modes, both inverted.
// RL19: inverted modes send and expect the complemented stage output.
`timescale 1ns/1ps
`include "pgc_defs.vh"

////////////////////////////////////////////////////////////////////////
module pgc_fifo #(
	parameter WIDTH = 1,
	parameter DEPTH = `PGC_FIFO_DEPTH,
	parameter AW    = `PGC_FIFO_AW
) (
	// clock and reset
	input  wire             clk_in,
	input  wire             reset_n_in,
	// fill side
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	// drain side
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	localparam [AW:0] FULL = DEPTH[AW:0];
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_q;
	reg [AW-1:0]    rd_ptr_q;
	reg [AW:0]      count_q;
	wire            push;
	wire            pop;

	assign in_ready_out  = (count_q != FULL);
	assign out_valid_out = (count_q != {(AW+1){1'b0}});
	assign out_data_out  = mem_q[rd_ptr_q];
	assign push = in_valid_in & in_ready_out;
	assign pop  = out_valid_out & out_ready_in;

	// depth must be a power of two, pointers wrap naturally
	always @(posedge clk_in) begin
		if (push)
			mem_q[wr_ptr_q] <= in_data_in;
	end

	always @(posedge clk_in) begin
		if (!reset_n_in) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule // pgc_fifo

////////////////////////////////////////////////////////////////////////
module pgc_top #(
	parameter [31:0] LOSS_WIN_CYC =
		`PGC_LOSS_WIN_S * (`PGC_NS_PER_S / `PGC_CLK_PERIOD_NS)
) (
	// clock and reset
	input  wire        clk_in,
	input  wire        reset_n_in,
	// generator setup
	input  wire [3:0]  gen_mode_in,
	input  wire [7:0]  user_pat_a_in,
	input  wire [7:0]  user_pat_b_in,
	input  wire [15:0] user_pat_w_in,
	// transmit stream
	input  wire        tx_ready_in,
	output wire        tx_data_out,
	output wire        tx_valid_out,
	// checker setup
	input  wire [3:0]  chk_mode_in,
	input  wire        line_code_in,
	input  wire [31:0] meas_len_in,
	input  wire        resync_in,
	// received pins
	input  wire        rx_pos_in,
	input  wire        rx_neg_in,
	input  wire        rx_strobe_in,
	// checker status
	output wire        sync_out,
	output wire        err_out,
	output wire        loss_out,
	output wire        meas_done_out,
	output wire [31:0] meas_err_out,
	output wire [31:0] meas_bits_out
);
	localparam ST_HUNT = 1'b0;
	localparam ST_LOCK = 1'b1;

	function [4:0] f_len;
		input [3:0] m;
		case (m)
			`PGC_M_P9:   f_len = 5'd9;
			`PGC_M_P11:  f_len = 5'd11;
			`PGC_M_P15:  f_len = 5'd15;
			`PGC_M_P20:  f_len = 5'd20;
			`PGC_M_P20Q: f_len = 5'd20;
			`PGC_M_P23:  f_len = 5'd23;
			`PGC_M_P29:  f_len = 5'd29;
			default:     f_len = 5'd31;
		endcase
	endfunction

	// RL3 RL4 RL5 RL6 RL8 RL18 feedback taps
	function [4:0] f_tap;
		input [3:0] m;
		case (m)
			`PGC_M_P9:   f_tap = 5'd5;
			`PGC_M_P11:  f_tap = 5'd9;
			`PGC_M_P15:  f_tap = 5'd14;
			`PGC_M_P20:  f_tap = 5'd3;
			`PGC_M_P20Q: f_tap = 5'd17;
			`PGC_M_P23:  f_tap = 5'd18;
			`PGC_M_P29:  f_tap = 5'd27;
			default:     f_tap = 5'd28;
		endcase
	endfunction

	// RL19 inverted modes
	function f_inv;
		input [3:0] m;
		f_inv = (m == `PGC_M_P15) | (m == `PGC_M_P23) |
			(m == `PGC_M_P29) | (m == `PGC_M_P31);
	endfunction

	// RL9 RL10 pattern words
	function [15:0] f_pword;
		input [3:0]  m;
		input [7:0]  pa;
		input [7:0]  pb;
		input [15:0] pw;
		case (m)
			`PGC_M_ONES: f_pword = `PGC_PW_ONES;
			`PGC_M_ALT:  f_pword = `PGC_PW_ALT;
			`PGC_M_ONE3: f_pword = `PGC_PW_ONE3;
			`PGC_M_USRA: f_pword = {8'h00, pa};
			`PGC_M_USRB: f_pword = {8'h00, pb};
			default:     f_pword = pw;
		endcase
	endfunction

	function [4:0] f_plen;
		input [3:0] m;
		case (m)
			`PGC_M_ONES: f_plen = 5'd1;
			`PGC_M_ALT:  f_plen = 5'd2;
			`PGC_M_ONE3: f_plen = 5'd4;
			`PGC_M_USRA: f_plen = 5'd8;
			`PGC_M_USRB: f_plen = 5'd8;
			default:     f_plen = 5'd16;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// generator
	reg  [30:0] gen_q;
	reg  [3:0]  gph_q;
	reg  [3:0]  gmode_q;
	reg         gvalid_q;
	wire [4:0]  g_n     = f_len(gen_mode_in);
	wire [4:0]  g_a     = f_tap(gen_mode_in);
	wire [4:0]  g_plen  = f_plen(gen_mode_in);
	wire [15:0] g_pword = f_pword(gen_mode_in, user_pat_a_in,
		user_pat_b_in, user_pat_w_in);
	wire [30:0] g_mask  = ~(31'h7FFF_FFFF << g_n);
	wire        g_prbs  = ~gen_mode_in[3];
	wire        g_fb    = gen_q[g_a - 5'd1] ^ gen_q[g_n - 5'd1];
	wire [4:0]  g_pidx  = g_plen - 5'd1 - {1'b0, gph_q};
	wire        g_pbit  = g_pword[g_pidx[3:0]];
	wire        g_force = gen_q[19] | ~|gen_q[18:5];
	wire        g_bit;
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire        fifo_out_data;
	wire        fifo_out_ready;
	wire        g_push  = gvalid_q & fifo_in_ready;

	// RL7 stage twenty out, forced one ahead of a long zero run
	// RL19 complement for inverted modes
	assign g_bit = !g_prbs ? g_pbit :
		(gen_mode_in == `PGC_M_P20Q) ? g_force :
		(g_fb ^ f_inv(gen_mode_in));

	always @(posedge clk_in) begin
		if (!reset_n_in) begin
			gen_q    <= `PGC_SEED;
			gph_q    <= 4'h0;
			gmode_q  <= 4'h0;
			gvalid_q <= 1'b0;
		end else begin
			gvalid_q <= 1'b1;
			gmode_q  <= gen_mode_in;
			// RL2 reseed on mode change or a stray zero state
			if (gmode_q != gen_mode_in || (gen_q & g_mask) == 31'h0) begin
				gen_q <= `PGC_SEED & g_mask;
				gph_q <= 4'h0;
			end else if (g_push) begin
				// RL1 shift with feedback
				gen_q <= {gen_q[29:0], g_fb} & g_mask;
				if ({1'b0, gph_q} == g_plen - 5'd1)
					gph_q <= 4'h0;
				else
					gph_q <= gph_q + 4'h1;
			end
		end
	end

	// fifo absorbs stalls of the transmit side
	pgc_fifo #(
		.WIDTH (1),
		.DEPTH (`PGC_FIFO_DEPTH),
		.AW    (`PGC_FIFO_AW)
	) u_fifo (
		.clk_in        (clk_in),
		.reset_n_in    (reset_n_in),
		.in_valid_in   (gvalid_q),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (g_bit),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_out_ready),
		.out_data_out  (fifo_out_data)
	);

	reg tx_valid_q;
	reg tx_data_q;
	assign fifo_out_ready = ~tx_valid_q | tx_ready_in;

	always @(posedge clk_in) begin
		if (!reset_n_in) begin
			tx_valid_q <= 1'b0;
			tx_data_q  <= 1'b0;
		end else if (fifo_out_ready) begin
			tx_valid_q <= fifo_out_valid;
			if (fifo_out_valid)
				tx_data_q <= fifo_out_data;
		end
	end

	////////////////////////////////////////////////////////////////////
	// receive synchronisers; second stages feed logic, strobe third stage only for edge detect
	reg pos_s1, pos_s2, neg_s1, neg_s2, stb_s1, stb_s2, stb_s3;
	always @(posedge clk_in) begin
		pos_s1 <= rx_pos_in;
		pos_s2 <= pos_s1;
		neg_s1 <= rx_neg_in;
		neg_s2 <= neg_s1;
		stb_s1 <= rx_strobe_in;
		stb_s2 <= stb_s1;
		stb_s3 <= stb_s2;
	end
	wire take = stb_s2 & ~stb_s3;

	////////////////////////////////////////////////////////////////////
	// checker
	reg  [30:0] chk_q;
	reg  [30:0] eh_q;
	reg  [3:0]  cph_q;
	reg  [3:0]  cmode_q;
	reg         st_q;
	reg         pol_q;
	reg  [6:0]  match_q;
	reg  [6:0]  oop_run_q;
	reg  [6:0]  oop_err_q;
	reg  [31:0] win_cyc_q, win_err_q, win_bits_q;
	reg  [31:0] m_cyc_q, m_err_q, m_bits_q;
	reg  [31:0] meas_err_q, meas_bits_q;
	reg         err_q, loss_q, done_q;
	wire [4:0]  c_n     = f_len(chk_mode_in);
	wire [4:0]  c_a     = f_tap(chk_mode_in);
	wire [4:0]  c_plen  = f_plen(chk_mode_in);
	wire [15:0] c_pword = f_pword(chk_mode_in, user_pat_a_in,
		user_pat_b_in, user_pat_w_in);
	wire [30:0] c_mask  = ~(31'h7FFF_FFFF << c_n);
	wire        c_prbs  = ~chk_mode_in[3];
	wire        c_inv   = c_prbs & f_inv(chk_mode_in);
	wire        c_fb    = chk_q[c_a - 5'd1] ^ chk_q[c_n - 5'd1];
	wire [4:0]  c_pidx  = c_plen - 5'd1 - {1'b0, cph_q};
	wire        c_ref   = c_prbs ? c_fb : c_pword[c_pidx[3:0]];
	// RL11 rails to binary
	wire        rx_bin  = line_code_in ? (pos_s2 | neg_s2) : pos_s2;
	// RL19 undo complement before comparison
	wire        rx_u    = rx_bin ^ c_inv;
	wire        mism    = rx_u ^ c_ref;
	// forced ones of the taps 17/20 variant are not errors
	wire        forced  = (chk_mode_in == `PGC_M_P20Q) & rx_u & ~c_ref;
	wire        ref_ln  = c_ref ^ c_inv;
	// RL16 mark polarity against ami-coded reference
	wire        ln_err  = line_code_in & ((pos_s2 & neg_s2) |
		(ref_ln & pos_s2 & pol_q) | (ref_ln & neg_s2 & ~pol_q));
	wire        bit_err = (mism & ~forced) | ln_err;
	// RL15 error stream obeying the recurrence means phase offset
	wire        e_pred  = eh_q[c_a - 5'd1] ^ eh_q[c_n - 5'd1];
	wire        oop_ok  = (bit_err == e_pred) && ((eh_q & c_mask) != 31'h0);
	wire        oop_hit = c_prbs && oop_ok &&
		(oop_run_q == `PGC_OOP_BITS - 7'd1) && (oop_err_q >= `PGC_OOP_ERRS);
	wire [33:0] err_x5  = {win_err_q, 2'b00} + {2'b00, win_err_q};
	wire        win_end = (win_cyc_q == LOSS_WIN_CYC - 32'd1);
	// RL13 ratio above 0.20 over the window
	wire        ratio_hit = win_end && (err_x5 > {2'b00, win_bits_q});
	wire        counted = (st_q == ST_LOCK) & take;
	wire        cnt_err = counted & bit_err;
	wire        m_end   = (meas_len_in != 32'h0) &&
		(m_cyc_q >= meas_len_in - 32'd1);
	wire [31:0] m_err_nx  = m_err_q + {31'h0, cnt_err};
	wire [31:0] m_bits_nx = m_bits_q + {31'h0, counted};

	always @(posedge clk_in) begin
		if (!reset_n_in) begin
			chk_q     <= `PGC_SEED;
			eh_q      <= 31'h0;
			cph_q     <= 4'h0;
			cmode_q   <= 4'h0;
			st_q      <= ST_HUNT;
			pol_q     <= 1'b0;
			match_q   <= 7'h0;
			oop_run_q <= 7'h0;
			oop_err_q <= 7'h0;
			win_cyc_q <= 32'h0;
			win_err_q <= 32'h0;
			win_bits_q <= 32'h0;
			err_q     <= 1'b0;
			loss_q    <= 1'b0;
		end else begin
			cmode_q <= chk_mode_in;
			err_q   <= cnt_err;
			loss_q  <= 1'b0;
			if (take && line_code_in && (pos_s2 ^ neg_s2)
				&& st_q == ST_HUNT)
				pol_q <= pos_s2;
			else if (take && st_q == ST_LOCK && ref_ln)
				pol_q <= ~pol_q;
			case (st_q)
			ST_HUNT: begin
				win_cyc_q  <= 32'h0;
				win_err_q  <= 32'h0;
				win_bits_q <= 32'h0;
				if (cmode_q != chk_mode_in || resync_in) begin
					match_q <= 7'h0;
				end else if (take) begin
					// received bits seed the reference
					chk_q <= {chk_q[29:0], rx_u} & c_mask;
					if (mism) begin
						match_q <= 7'h0;
						// slip one extra phase to hunt the pattern
						if ({1'b0, cph_q} >= c_plen - 5'd2)
							cph_q <= cph_q + 4'h2 - c_plen[3:0];
						else
							cph_q <= cph_q + 4'h2;
					end else begin
						if ({1'b0, cph_q} == c_plen - 5'd1)
							cph_q <= 4'h0;
						else
							cph_q <= cph_q + 4'h1;
						if (match_q == `PGC_SYNC_BITS - 7'd1) begin
							match_q   <= 7'h0;
							st_q      <= ST_LOCK;
							eh_q      <= 31'h0;
							oop_run_q <= 7'h0;
							oop_err_q <= 7'h0;
						end else begin
							match_q <= match_q + 7'd1;
						end
					end
				end
			end
			ST_LOCK: begin
				if (cmode_q != chk_mode_in || resync_in) begin
					st_q <= ST_HUNT;
				// RL13 RL14 lose lock and hunt again
				end else if (ratio_hit || (take && oop_hit)) begin
					st_q   <= ST_HUNT;
					loss_q <= 1'b1;
				end else begin
					win_cyc_q  <= win_end ? 32'h0 : win_cyc_q + 32'd1;
					win_err_q  <= win_end ? 32'h0 :
						win_err_q + {31'h0, cnt_err};
					win_bits_q <= win_end ? 32'h0 :
						win_bits_q + {31'h0, counted};
					if (take) begin
						chk_q <= {chk_q[29:0], c_fb} & c_mask;
						eh_q  <= {eh_q[29:0], bit_err} & c_mask;
						if ({1'b0, cph_q} == c_plen - 5'd1)
							cph_q <= 4'h0;
						else
							cph_q <= cph_q + 4'h1;
						if (oop_ok) begin
							oop_run_q <= oop_run_q + 7'd1;
							if (bit_err && oop_err_q != 7'h7F)
								oop_err_q <= oop_err_q + 7'd1;
						end else begin
							oop_run_q <= 7'h0;
							oop_err_q <= 7'h0;
						end
					end
				end
			end
			default: st_q <= ST_HUNT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// RL17 interval measurement
	// RL12 only locked bits and errors reach the counters
	always @(posedge clk_in) begin
		if (!reset_n_in) begin
			m_cyc_q     <= 32'h0;
			m_err_q     <= 32'h0;
			m_bits_q    <= 32'h0;
			meas_err_q  <= 32'h0;
			meas_bits_q <= 32'h0;
			done_q      <= 1'b0;
		end else begin
			done_q <= m_end;
			if (m_end) begin
				m_cyc_q     <= 32'h0;
				m_err_q     <= 32'h0;
				m_bits_q    <= 32'h0;
				meas_err_q  <= m_err_nx;
				meas_bits_q <= m_bits_nx;
			end else if (meas_len_in != 32'h0) begin
				m_cyc_q  <= m_cyc_q + 32'd1;
				m_err_q  <= m_err_nx;
				m_bits_q <= m_bits_nx;
			end
		end
	end

	assign tx_data_out   = tx_data_q;
	assign tx_valid_out  = tx_valid_q;
	assign sync_out      = st_q;
	assign err_out       = err_q;
	assign loss_out      = loss_q;
	assign meas_done_out = done_q;
	assign meas_err_out  = meas_err_q;
	assign meas_bits_out = meas_bits_q;
endmodule // pgc_top

// *** pgc_top_assertions.sv ***
/* checker bound to pgc_top: pulse widths, lock gating, transmit hold
   and measurement results.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`include "pgc_defs.vh"
////////////////////////////////////////////////////////////////////////
module pgc_chk #(
	parameter [31:0] LOSS_WIN_CYC = 32'h0000_07D0
) (
	// clock and reset
	input wire        clk_in,
	input wire        reset_n_in,
	// watched ports
	input wire [3:0]  gen_mode_in,
	input wire        tx_ready_in,
	input wire        tx_data_out,
	input wire        tx_valid_out,
	input wire [31:0] meas_len_in,
	input wire        resync_in,
	input wire        sync_out,
	input wire        err_out,
	input wire        loss_out,
	input wire        meas_done_out,
	input wire [31:0] meas_err_out,
	input wire [31:0] meas_bits_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// saturates so a long run cannot wrap back under the limit
	reg  [4:0] zr_q;
	wire [4:0] zr_d = tx_data_out ? 5'h00 :
		(zr_q == 5'h1F) ? zr_q : zr_q + 5'h01;
	always @(posedge clk_in) begin
		if (!reset_n_in)
			zr_q <= 5'h00;
		else if (tx_valid_out && tx_ready_in)
			zr_q <= zr_d;
	end
	sequence s_hold;
		resync_in [*4];
	endsequence
	sequence s_idle;
		(!sync_out && !loss_out) [*2];
	endsequence
	property p_resync;
		s_hold |-> s_idle;
	endproperty
	a_resync: assert property (p_resync)
		else $error("lock kept during resync");
	property p_loss_drop;
		loss_out |=> s_idle;
	endproperty
	a_loss_drop: assert property (p_loss_drop)
		else $error("lock kept after loss");
	property p_loss_lock;
		loss_out |-> $past(sync_out);
	endproperty
	a_loss_lock: assert property (p_loss_lock)
		else $error("loss without lock");
	property p_err_lock;
		err_out |-> $past(sync_out);
	endproperty
	a_err_lock: assert property (p_err_lock)
		else $error("error counted while hunting");
	property p_err_pulse;
		err_out |=> !err_out;
	endproperty
	a_err_pulse: assert property (p_err_pulse)
		else $error("error pulse too long");
	property p_done;
		meas_done_out |=> !meas_done_out;
	endproperty
	a_done: assert property (p_done)
		else $error("done pulse too long");
	property p_meas_hold;
		!$stable(meas_err_out) || !$stable(meas_bits_out) |-> meas_done_out;
	endproperty
	a_meas_hold: assert property (p_meas_hold)
		else $error("result moved between intervals");
	property p_meas_sane;
		meas_done_out |-> meas_len_in != 32'h0 && meas_err_out <= meas_bits_out;
	endproperty
	a_meas_sane: assert property (p_meas_sane)
		else $error("bad interval result");
	property p_tx_hold;
		tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("tx bit dropped before accept");
	property p_zero_run;
		gen_mode_in == `PGC_M_P20Q |-> zr_q <= 5'h0E;
	endproperty
	a_zero_run: assert property (p_zero_run)
		else $error("zero run above fourteen");
endmodule // pgc_chk

bind pgc_top pgc_chk #(.LOSS_WIN_CYC(LOSS_WIN_CYC)) u_chk (
	.clk_in(clk_in), .reset_n_in(reset_n_in), .gen_mode_in(gen_mode_in),
	.tx_ready_in(tx_ready_in), .tx_data_out(tx_data_out),
	.tx_valid_out(tx_valid_out), .meas_len_in(meas_len_in),
	.resync_in(resync_in), .sync_out(sync_out), .err_out(err_out),
	.loss_out(loss_out), .meas_done_out(meas_done_out),
	.meas_err_out(meas_err_out), .meas_bits_out(meas_bits_out));

// *** pgc_path_model.sv ***
/* path model: takes one tx bit every four clocks and replays it on the
   receive rails with a strobe; flip and drop spoil the stream.
   assumes the clock and reset of the block. */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module pgc_path (
	// clock and reset
	input  wire clk_in,
	input  wire reset_n_in,
	// bench control
	input  wire ami_in,
	input  wire flip_in,
	input  wire drop_in,
	// transmit side
	input  wire tx_data_in,
	input  wire tx_valid_in,
	output reg  tx_ready_out,
	// receive pins
	output reg  rx_pos_out,
	output reg  rx_neg_out,
	output reg  rx_strobe_out
);
	reg  [1:0] ph_q;
	reg        pol_q;
	reg        got_q;
	wire       take = tx_valid_in & tx_ready_out;
	always @(posedge clk_in) begin
		if (!reset_n_in) begin
			ph_q <= 2'h0;
			pol_q <= 1'b0;
			got_q <= 1'b0;
			tx_ready_out <= 1'b0;
			rx_strobe_out <= 1'b0;
			rx_pos_out <= 1'b0;
			rx_neg_out <= 1'b0;
		end else begin
			ph_q <= ph_q + 2'h1;
			tx_ready_out <= (ph_q == 2'h2);
			// strobe high two and low two clocks, rails settled
			if (ph_q == 2'h1)
				rx_strobe_out <= got_q;
			if (ph_q == 2'h3) begin
				rx_strobe_out <= 1'b0;
				got_q <= take & ~drop_in;
			end
			if (take && !ami_in) begin
				rx_pos_out <= tx_data_in ^ flip_in;
				rx_neg_out <= 1'b0;
			end else if (take && flip_in) begin
				// both rails high: line fault only, encoder still alternates
				rx_pos_out <= 1'b1;
				rx_neg_out <= 1'b1;
				pol_q <= pol_q ^ tx_data_in;
			end else if (take) begin
				rx_pos_out <= tx_data_in & pol_q;
				rx_neg_out <= tx_data_in & ~pol_q;
				pol_q <= pol_q ^ tx_data_in;
			end
		end
	end
endmodule // pgc_path

// *** pgc_top_tb_top.sv ***
/* bench for pgc_top: mode table, then error count, line code, resync,
   slip and ratio cases.
   assumes pgc_path loops tx bits back at one per four clocks. */
`timescale 1ns/1ps
`include "pgc_defs.vh"
////////////////////////////////////////////////////////////////////////
module pgc_top_tb_top;
	typedef struct {
		logic [3:0]  m;
		int          a;
		int          n;
		logic        inv;
		logic [15:0] w;
		int          len;
	} pgc_row_t;
	reg         clk_in = 1'b0;
	reg         reset_n_in = 1'b0;
	reg  [3:0]  gen_mode = `PGC_M_P9;
	reg  [3:0]  chk_mode = `PGC_M_P9;
	reg         line_code = 1'b0;
	reg         resync = 1'b0;
	reg         flip = 1'b0;
	reg         drop = 1'b0;
	wire        tx_data, tx_valid, tx_ready;
	wire        rx_pos, rx_neg, rx_strobe;
	wire        sync, err, loss, done;
	wire [31:0] m_err, m_bits;
	int         n_fail = 0;
	int         n_checks = 0;
	int         n_err = 0;
	int         n_loss = 0;
	int         cap_n = 0;
	int         e0;
	logic       cap [0:63];
	pgc_row_t   rows [0:13] = '{
		'{`PGC_M_P9, 5, 9, 1'b0, 16'h0000, 0},
		'{`PGC_M_P11, 9, 11, 1'b0, 16'h0000, 0},
		'{`PGC_M_P20, 3, 20, 1'b0, 16'h0000, 0},
		'{`PGC_M_P23, 18, 23, 1'b1, 16'h0000, 0},
		'{`PGC_M_P29, 27, 29, 1'b1, 16'h0000, 0},
		'{`PGC_M_P31, 28, 31, 1'b1, 16'h0000, 0},
		'{`PGC_M_P20Q, 1, 1, 1'b0, 16'h0000, -1},
		'{`PGC_M_ONES, 1, 1, 1'b0, `PGC_PW_ONES, 1},
		'{`PGC_M_ALT, 1, 1, 1'b0, `PGC_PW_ALT, 2},
		'{`PGC_M_ONE3, 1, 1, 1'b0, `PGC_PW_ONE3, 4},
		'{`PGC_M_USRA, 1, 1, 1'b0, 16'h00A7, 8},
		'{`PGC_M_USRB, 1, 1, 1'b0, 16'h003C, 8},
		'{`PGC_M_USRW, 1, 1, 1'b0, 16'h5A0F, 16},
		'{`PGC_M_P15, 14, 15, 1'b1, 16'h0000, 0}};
	always #5 clk_in = ~clk_in;
	// short loss window keeps the ratio case quick
	pgc_top #(.LOSS_WIN_CYC(32'h0000_07D0)) u_dut (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .gen_mode_in(gen_mode),
		.user_pat_a_in(8'hA7), .user_pat_b_in(8'h3C),
		.user_pat_w_in(16'h5A0F), .tx_ready_in(tx_ready),
		.tx_data_out(tx_data), .tx_valid_out(tx_valid),
		.chk_mode_in(chk_mode), .line_code_in(line_code),
		.meas_len_in(32'h0000_07D0), .resync_in(resync),
		.rx_pos_in(rx_pos), .rx_neg_in(rx_neg), .rx_strobe_in(rx_strobe),
		.sync_out(sync), .err_out(err), .loss_out(loss),
		.meas_done_out(done), .meas_err_out(m_err), .meas_bits_out(m_bits));
	pgc_path u_path (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .ami_in(line_code),
		.flip_in(flip), .drop_in(drop), .tx_data_in(tx_data),
		.tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
		.rx_pos_out(rx_pos), .rx_neg_out(rx_neg), .rx_strobe_out(rx_strobe));
	always @(posedge clk_in) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1 && cap_n < 64) begin
			cap[cap_n] = tx_data;
			cap_n++;
		end
		if (err === 1'b1)
			n_err++;
		if (loss === 1'b1)
			n_loss++;
	end
	function automatic logic expb(pgc_row_t r, int k);
		logic x [0:95];
		for (int j = 0; j <= k + 31; j++)
			x[j] = (j < 31) ? 1'b1 : x[j - r.a] ^ x[j - r.n];
		if (r.len > 0)
			return r.w[r.len - 1 - k % r.len];
		return x[k + 31] ^ r.inv;
	endfunction
	task tick;
		@(posedge clk_in);
		#1;
	endtask
	task chk1(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t bit got %b exp %b", $time, g, e);
		end
	endtask
	task chk32(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t count got %0d exp %0d", $time, g, e);
		end
	endtask
	task do_reset;
		reset_n_in = 1'b0;
		repeat (3) tick;
		chk1(sync, 1'b0);
		chk1(tx_valid, 1'b0);
		cap_n = 0;
		reset_n_in = 1'b1;
	endtask
	task wait_sync;
		for (int i = 0; i < 8000 && sync !== 1'b1; i++)
			tick;
	endtask
	task wait_done;
		for (int i = 0; i < 3000 && done !== 1'b1; i++)
			tick;
	endtask
	task rehunt;
		resync = 1'b1;
		repeat (6) tick;
		chk1(sync, 1'b0);
		resync = 1'b0;
		wait_sync;
	endtask
	// one bit spoilt: w set flips it, clear drops it
	task hit(input int w);
		flip = (w != 0);
		drop = (w == 0);
		repeat (4) tick;
		flip = 1'b0;
		drop = 1'b0;
		repeat (40) tick;
	endtask
	task results;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#900_000;
		n_fail++;
		results;
	end
	initial begin
		foreach (rows[i]) begin
			gen_mode = rows[i].m;
			chk_mode = rows[i].m;
			do_reset;
			wait_sync;
			chk1(sync, 1'b1);
			for (int k = 0; k < 48 && rows[i].len >= 0; k++)
				chk1(cap[k], expb(rows[i], k));
		end
		wait_done;
		e0 = n_err;
		repeat (3) hit(1);
		wait_done;
		chk32(m_err, 32'h0000_0003);
		chk32(m_bits, 32'h0000_01F4);
		chk32(32'(n_err - e0), 32'h0000_0003);
		line_code = 1'b1;
		rehunt;
		e0 = n_err;
		repeat (400) tick;
		hit(1);
		chk32(32'(n_err - e0), 32'h0000_0001);
		chk32(32'(n_loss), 32'h0000_0000);
		line_code = 1'b0;
		rehunt;
		e0 = n_loss;
		hit(0);
		for (int i = 0; i < 1500 && n_loss == e0; i++)
			tick;
		chk32(32'(n_loss - e0), 32'h0000_0001);
		wait_sync;
		e0 = n_loss;
		gen_mode = `PGC_M_P9;
		for (int i = 0; i < 6000 && n_loss == e0; i++)
			tick;
		chk32(32'(n_loss - e0), 32'h0000_0001);
		results;
	end
endmodule // pgc_top_tb_top
